// File: shared/tscp_pkg.sv
// constants shared by both ends of the tdm serial channel port link
package tscp_pkg;
   // ----------------------------------------------------------------
   // clocking and frame timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 250000000;
   localparam int unsigned DATA_KBPS      = 2048;
   localparam int unsigned SLOT_KBPS      = 64;
   localparam int unsigned LINK_HZ        = 2 * DATA_KBPS * 1000;
   localparam int unsigned FRAME_US       = 125;
   localparam int unsigned FRAME_PULSE_NS = 244;
   localparam int unsigned NUM_SLOTS      = DATA_KBPS / SLOT_KBPS;
   localparam int unsigned SLOT_BITS      = 8;
   localparam int unsigned USED_SLOTS     = 4;
   localparam int unsigned CELL_EDGES     = 2;
   localparam int unsigned FRAME_FALLS    = NUM_SLOTS * SLOT_BITS * CELL_EDGES;
   localparam int unsigned CNT_W          = $clog2(FRAME_FALLS);
   // half period of the link clock made by the far end, rounded down
   localparam int unsigned HALF_DIV       = CLK_HZ / (2 * LINK_HZ);
   localparam int unsigned DIV_W          = $clog2(HALF_DIV);

   // ----------------------------------------------------------------
   // device registers on its own register port
   // ----------------------------------------------------------------
   localparam int unsigned  REG_AW          = 6;
   localparam logic [5:0]   REG_CTRL_CHAN   = 6'h14;
   localparam logic [5:0]   REG_SLOT_TIMING = 6'h15;
   localparam logic [7:0]   CTRL_CHAN_RST   = 8'h00;
   localparam logic [7:0]   SLOT_TIMING_RST = 8'h00;
   localparam int unsigned  SLOT0_EN_BIT    = 0;
   localparam int unsigned  SLOT1_EN_BIT    = 1;
   localparam int unsigned  SLOT2_EN_BIT    = 2;
   localparam int unsigned  SLOT3_EN_BIT    = 3;
   localparam logic         IDLE_LEVEL      = 1'b1;

   // ----------------------------------------------------------------
   // far-end controller registers on apb
   // ----------------------------------------------------------------
   localparam logic [7:0]   APB_CTRL        = 8'h00;
   localparam logic [7:0]   APB_TX_SLOTS    = 8'h04;
   localparam logic [7:0]   APB_RX_SLOTS    = 8'h08;
   localparam logic [7:0]   APB_STATUS      = 8'h0C;
   localparam int unsigned  CTRL_RUN_BIT    = 0;
   localparam logic [31:0]  APB_WORD_RST    = 32'h0000_0000;
endpackage

// File: shared/tscp_link_if.sv
// serial link between the device end and the transceiver end
`timescale 1ns/1ps
interface tscp_link_if;
   logic link_bit_clock;
   logic frame_pulse_in_n;
   logic serial_in_stream;
   logic serial_out_stream;
   logic serial_out_stream_oe;
   logic serial_out_line;

   // tri-stated output line settles at the idle level through a pull-up
   assign serial_out_line = serial_out_stream_oe ? serial_out_stream : 1'b1;

   modport device (
      input  link_bit_clock,
      input  frame_pulse_in_n,
      input  serial_in_stream,
      output serial_out_stream,
      output serial_out_stream_oe
   );
   modport xcvr (
      output link_bit_clock,
      output frame_pulse_in_n,
      output serial_in_stream,
      input  serial_out_line
   );
endinterface

// File: design/tscp_device.sv
// device end of the tdm serial channel port: slot timing, slots 0-3, registers
// Behaviour
// R1 - 2048 kb/s streams, 32 slots of 64 kb/s
// R2 - far end sends 244 ns low frame pulse
// R3 - frame repeats every 125 us
// R4 - frame valid when pulse low at falling clock
// R5 - far end bit clock is twice data rate
// R6 - sample at 3/4 cell, drive at start
// R7 - link clock times channels and internal functions
// R8 - only first four slots after pulse used
// R9 - one enable bit per slot in timing register
// R10 - slot 0: two low bits, rest tri-stated
// R11 - slot 0 enable: hdlc bits, else zeros
// R12 - incoming slot 0 always goes to hdlc
// R13 - slot 1 enable: drive register, else tri-state
// R14 - incoming slot 1 always captured to register
// R15 - control channel bytes travel msb first
// R16 - double-buffered control channel register at 14h
// R17 - latest written byte sent every frame
// R18 - slots 2 and 3 are pcm, own enables
// R19 - pcm slot enabled: send pcm, else zeros; with slots 2 and 3 both enabled, slot 3 sends zeros
// R20 - pcm receive from enabled slot, slot 2 wins
// R21 - read buffer updated only after full byte
`timescale 1ns/1ps
module tscp_device
   import tscp_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              reset,
   tscp_link_if.device            link,
   input  wire logic [REG_AW-1:0] reg_addr,
   input  wire logic              reg_wr,
   input  wire logic [7:0]        reg_wdata,
   output logic      [7:0]        reg_rdata,
   input  wire logic [1:0]        hdlc_tx_bits,
   output logic      [1:0]        hdlc_rx_bits,
   output logic                   hdlc_rx_valid,
   input  wire logic [7:0]        pcm_tx_byte,
   output logic      [7:0]        pcm_rx_byte,
   output logic                   pcm_rx_valid,
   output logic                   frame_locked
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0]       clk_sync;
   logic [1:0]       fp_sync;
   logic [1:0]       din_sync;
   logic             link_fall;
   logic             link_rise;

   // every link pin passes two flops; a third clock stage finds the edges
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         clk_sync <= 3'h0;
         fp_sync  <= 2'h3;
         din_sync <= 2'h3;
      end else begin
         clk_sync <= {clk_sync[1:0], link.link_bit_clock};
         fp_sync  <= {fp_sync[0], link.frame_pulse_in_n};
         din_sync <= {din_sync[0], link.serial_in_stream};
      end
   end

   // all timing below runs off link clock edges, not a free-running count
   assign link_fall = clk_sync[2] & ~clk_sync[1]; // R7
   assign link_rise = ~clk_sync[2] & clk_sync[1]; // R7

   // ----------------------------------------------------------------
   // frame position
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] fall_cnt;
   logic [CNT_W-1:0] next_fall_cnt;
   logic             frame_start;
   logic [4:0]       next_slot;
   logic [2:0]       next_bit;
   logic [4:0]       cur_slot;
   logic [2:0]       cur_bit;
   logic             cell_start;
   logic             sample_pt;

   // pulse counts only when seen low at a falling link edge
   assign frame_start   = link_fall & ~fp_sync[1]; // R4
   // 512 falling edges span 32 slots of 8 two-clock cells
   assign next_fall_cnt = frame_start ? '0 : CNT_W'(fall_cnt + 1'b1); // R1 R3 R5
   assign next_slot     = next_fall_cnt[CNT_W-1 -: 5];
   assign next_bit      = 3'h7 - next_fall_cnt[3:1]; // R15
   assign cur_slot      = fall_cnt[CNT_W-1 -: 5];
   assign cur_bit       = 3'h7 - fall_cnt[3:1];
   // even fall opens a cell, rise after the odd fall is its 3/4 point
   assign cell_start    = link_fall & ~next_fall_cnt[0] & (frame_locked | frame_start); // R4 R6
   assign sample_pt     = link_rise & fall_cnt[0] & frame_locked; // R6

   // position counter follows the far end's falling edges
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         fall_cnt <= '0;
      end else if (link_fall) begin
         fall_cnt <= next_fall_cnt;
      end
   end

   // no slot is touched until the first valid frame pulse
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         frame_locked <= 1'b0;
      end else if (frame_start) begin
         frame_locked <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0]       cc_tx_buf;
   logic [7:0]       cc_rx_buf;
   logic [7:0]       slot_timing;
   logic [7:0]       cc_tx_shift;
   logic [7:0]       cc_rx_shift;
   logic [7:0]       pcm_tx_hold;
   logic [7:0]       pcm_rx_shift;
   logic             slot0_enable;
   logic             slot1_enable;
   logic             slot2_enable;
   logic             slot3_enable;
   logic [4:0]       pcm_rx_slot;
   logic [4:0]       pcm_tx_slot;
   logic             pcm_rx_on;
   logic             pcm_tx_on;

   assign slot0_enable = slot_timing[SLOT0_EN_BIT]; // R9
   assign slot1_enable = slot_timing[SLOT1_EN_BIT]; // R9
   assign slot2_enable = slot_timing[SLOT2_EN_BIT]; // R9
   assign slot3_enable = slot_timing[SLOT3_EN_BIT]; // R9

   // slot 2 takes precedence when both pcm enables are set
   assign pcm_tx_on   = slot2_enable | slot3_enable; // R18
   assign pcm_tx_slot = slot2_enable ? 5'd2 : 5'd3; // R20
   assign pcm_rx_on   = pcm_tx_on; // R20
   assign pcm_rx_slot = pcm_tx_slot; // R20

   // write side of the control channel and timing register
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         cc_tx_buf   <= CTRL_CHAN_RST;
         slot_timing <= SLOT_TIMING_RST;
      end else if (reg_wr) begin
         if (reg_addr == REG_CTRL_CHAN) begin
            cc_tx_buf <= reg_wdata; // R16
         end
         if (reg_addr == REG_SLOT_TIMING) begin
            slot_timing <= reg_wdata; // R9
         end
      end
   end

   // read mux is registered; unmapped addresses read zero
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else begin
         case (reg_addr)
            REG_CTRL_CHAN:   reg_rdata <= cc_rx_buf; // R16
            REG_SLOT_TIMING: reg_rdata <= slot_timing;
            default:         reg_rdata <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // transmit side
   // ----------------------------------------------------------------
   // second buffer stage: a host write mid-slot never tears the byte
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         cc_tx_shift <= CTRL_CHAN_RST;
         pcm_tx_hold <= 8'h00;
      end else if (frame_start) begin
         cc_tx_shift <= cc_tx_buf; // R16 R17
         pcm_tx_hold <= pcm_tx_byte;
      end
   end

   // new bit put out at each cell start; slots beyond 3 left tri-stated
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         link.serial_out_stream    <= IDLE_LEVEL;
         link.serial_out_stream_oe <= 1'b0;
      end else if (cell_start) begin
         link.serial_out_stream    <= IDLE_LEVEL;
         link.serial_out_stream_oe <= 1'b0; // R8
         if (next_slot == 5'd0) begin
            if (next_bit < 3'd2) begin
               link.serial_out_stream_oe <= 1'b1; // R10
               link.serial_out_stream    <= slot0_enable & hdlc_tx_bits[next_bit[0]]; // R11
            end
         end else if (next_slot == 5'd1) begin
            link.serial_out_stream_oe <= slot1_enable; // R13
            link.serial_out_stream    <= cc_tx_shift[next_bit]; // R15 R17
         end else if (next_slot == 5'd2 || next_slot == 5'd3) begin
            link.serial_out_stream_oe <= 1'b1;
            // zeros when this pcm slot is not the selected one
            link.serial_out_stream    <= pcm_tx_on && next_slot == pcm_tx_slot
                                         && pcm_tx_hold[next_bit]; // R19
         end
      end
   end

   // ----------------------------------------------------------------
   // receive side
   // ----------------------------------------------------------------
   // d-channel pair handed on every frame regardless of enable
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         hdlc_rx_bits  <= 2'h0;
         hdlc_rx_valid <= 1'b0;
      end else begin
         hdlc_rx_valid <= 1'b0;
         if (sample_pt && cur_slot == 5'd0 && cur_bit < 3'd2) begin
            hdlc_rx_bits[cur_bit[0]] <= din_sync[1]; // R12
            hdlc_rx_valid            <= cur_bit == 3'd0; // R12
         end
      end
   end

   // control channel shifted in msb first, always, whatever the enable
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         cc_rx_shift <= 8'h00;
         cc_rx_buf   <= CTRL_CHAN_RST;
      end else if (sample_pt && cur_slot == 5'd1) begin
         cc_rx_shift <= {cc_rx_shift[6:0], din_sync[1]}; // R14 R15
         if (cur_bit == 3'd0) begin
            cc_rx_buf <= {cc_rx_shift[6:0], din_sync[1]}; // R21
         end
      end
   end

   // pcm taken from the selected b slot only when it is enabled
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pcm_rx_shift <= 8'h00;
         pcm_rx_byte  <= 8'h00;
         pcm_rx_valid <= 1'b0;
      end else begin
         pcm_rx_valid <= 1'b0;
         if (sample_pt && pcm_rx_on && cur_slot == pcm_rx_slot) begin
            pcm_rx_shift <= {pcm_rx_shift[6:0], din_sync[1]}; // R20
            if (cur_bit == 3'd0) begin
               pcm_rx_byte  <= {pcm_rx_shift[6:0], din_sync[1]}; // R20
               pcm_rx_valid <= 1'b1;
            end
         end
      end
   end

endmodule // tscp_device

// File: design/tscp_xcvr.sv
// transceiver end: makes link clock and frame pulse, apb-controlled slot data
`timescale 1ns/1ps
module tscp_xcvr
   import tscp_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        reset,
   tscp_link_if.xcvr        link,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);
   // ----------------------------------------------------------------
   // apb registers
   // ----------------------------------------------------------------
   logic [31:0]      ctrl;
   logic [31:0]      tx_slots;
   logic [31:0]      rx_slots;
   logic [15:0]      frame_count;
   logic             apb_done;
   logic             addr_ok;

   assign apb_done = psel & penable & pready;
   assign addr_ok  = paddr == APB_CTRL || paddr == APB_TX_SLOTS
                     || paddr == APB_RX_SLOTS || paddr == APB_STATUS;

   // zero-wait slave: answer prepared in setup, taken in first access cycle
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= APB_WORD_RST;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_ok;
         case (paddr)
            APB_CTRL:     prdata <= ctrl;
            APB_TX_SLOTS: prdata <= tx_slots;
            APB_RX_SLOTS: prdata <= rx_slots;
            APB_STATUS:   prdata <= {16'h0000, frame_count};
            default:      prdata <= APB_WORD_RST;
         endcase
      end
   end

   // writes land only on the completing access edge
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ctrl     <= APB_WORD_RST;
         tx_slots <= APB_WORD_RST;
      end else if (apb_done && pwrite) begin
         if (paddr == APB_CTRL) begin
            ctrl <= pwdata;
         end
         if (paddr == APB_TX_SLOTS) begin
            tx_slots <= pwdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // link clock and frame timing
   // ----------------------------------------------------------------
   logic [DIV_W-1:0] div_cnt;
   logic [CNT_W-1:0] fall_cnt;
   logic             toggle;
   logic             run;
   logic [1:0]       line_sync;
   logic [31:0]      tx_hold;
   logic [31:0]      rx_shift;
   logic [CNT_W-1:0] next_cnt;

   assign run      = ctrl[CTRL_RUN_BIT];
   assign toggle   = run && div_cnt == DIV_W'(HALF_DIV - 1);
   assign next_cnt = CNT_W'(fall_cnt + 1'b1);

   // returned line passes two flops before it is sampled
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         line_sync <= 2'h3;
      end else begin
         line_sync <= {line_sync[0], link.serial_out_line};
      end
   end

   // divider from the system clock; link clock held low while stopped
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         div_cnt             <= '0;
         link.link_bit_clock <= 1'b0;
      end else if (!run) begin
         div_cnt             <= '0;
         link.link_bit_clock <= 1'b0;
      end else if (toggle) begin
         div_cnt             <= '0;
         link.link_bit_clock <= ~link.link_bit_clock; // R5
      end else begin
         div_cnt <= DIV_W'(div_cnt + 1'b1);
      end
   end

   // pulse moves only on rises, so it is steady at the fall that opens the frame
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         fall_cnt              <= '1;
         link.frame_pulse_in_n <= 1'b1;
         frame_count           <= 16'h0000;
         tx_hold               <= APB_WORD_RST;
      end else if (!run) begin
         fall_cnt              <= '1;
         link.frame_pulse_in_n <= 1'b1;
      end else if (toggle) begin
         if (link.link_bit_clock) begin
            fall_cnt <= next_cnt; // R1 R3
            if (next_cnt == '0) begin
               frame_count <= 16'(frame_count + 1'b1);
               tx_hold     <= tx_slots;
            end
         end else begin
            link.frame_pulse_in_n <= ~(fall_cnt == '1); // R2
         end
      end
   end

   // slots 0-3 driven msb first from the held word, idle high elsewhere
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         link.serial_in_stream <= IDLE_LEVEL;
      end else if (toggle && link.link_bit_clock && !next_cnt[0]) begin
         if (next_cnt[CNT_W-1:1] < 8'd32) begin
            link.serial_in_stream <= (next_cnt == '0) ? tx_slots[31]
                                     : tx_hold[5'd31 - next_cnt[5:1]];
         end else begin
            link.serial_in_stream <= IDLE_LEVEL;
         end
      end
   end

   // return slots 0-3 sampled at the 3/4 point, word kept per frame
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rx_shift <= APB_WORD_RST;
         rx_slots <= APB_WORD_RST;
      end else if (toggle && !link.link_bit_clock && fall_cnt[0]
                   && fall_cnt[CNT_W-1:1] < 8'd32) begin
         rx_shift <= {rx_shift[30:0], line_sync[1]};
         if (fall_cnt[CNT_W-1:1] == 8'd31) begin
            rx_slots <= {rx_shift[30:0], line_sync[1]};
         end
      end
   end

endmodule // tscp_xcvr

// File: dv/tscp_link_asserts.sv
// link-level assertions for the tdm serial channel port
`timescale 1ns/1ps
module tscp_link_asserts
   import tscp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic link_bit_clock,
   input wire logic frame_pulse_in_n,
   input wire logic serial_out_stream,
   input wire logic serial_out_stream_oe
);
   // ------------------------------------------------------------
   // link timing trackers
   // ------------------------------------------------------------
   logic       lbc_q;
   logic       fall;
   logic       seen;
   logic       s1_oe;
   logic [8:0] fidx;
   logic [7:0] age;
   logic [7:0] hi_cnt;
   assign fall = lbc_q & ~link_bit_clock;
   // age since last fall saturates, so a stopped clock never wraps it
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         lbc_q  <= 1'b0;
         age    <= 8'hFF;
         hi_cnt <= 8'h00;
      end else begin
         lbc_q  <= link_bit_clock;
         age    <= fall ? 8'h00 : ((age == 8'hFF) ? age : age + 8'h01);
         hi_cnt <= link_bit_clock ? hi_cnt + 8'h01 : 8'h00;
      end
   end
   // fall index in frame; index 0 is the fall that carries the pulse
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         fidx  <= 9'h000;
         seen  <= 1'b0;
         s1_oe <= 1'b0;
      end else begin
         if (fall) begin
            fidx <= frame_pulse_in_n ? fidx + 9'h001 : 9'h000;
            seen <= seen | ~frame_pulse_in_n;
         end
         if ((fidx == 9'h010) && (age == 8'h0B)) begin
            s1_oe <= serial_out_stream_oe;
         end
      end
   end
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   property p_quiet_after_reset;
      $fell(reset) |-> !serial_out_stream_oe [*8];
   endproperty
   property p_cell_start;
      seen && ($changed(serial_out_stream) || $changed(serial_out_stream_oe))
         |-> (age <= 8'h0A) && !fidx[0];
   endproperty
   property p_high_slots_quiet;
      seen && (fidx >= 9'd64) && (age > 8'h0A) |-> !serial_out_stream_oe;
   endproperty
   property p_slot0_upper;
      seen && (fidx < 9'd12) && (age > 8'h0A) |-> !serial_out_stream_oe;
   endproperty
   property p_slot0_low;
      seen && (fidx inside {[12:15]}) && (age > 8'h0A) |-> serial_out_stream_oe;
   endproperty
   property p_pcm_driven;
      seen && (fidx inside {[32:63]}) && (age > 8'h0A) |-> serial_out_stream_oe;
   endproperty
   property p_slot1_whole;
      seen && (fidx inside {[17:31]}) && (age > 8'h0A) |-> serial_out_stream_oe == s1_oe;
   endproperty
   property p_frame_spacing;
      seen && fall && !frame_pulse_in_n |-> fidx == 9'd511;
   endproperty
   property p_clock_half;
      $fell(link_bit_clock) |-> hi_cnt == 8'(HALF_DIV);
   endproperty
   a_quiet_after_reset: assert property (p_quiet_after_reset)
      else $error("link driven before any frame pulse");
   a_cell_start: assert property (p_cell_start)
      else $error("output changed away from a cell start");
   a_high_slots_quiet: assert property (p_high_slots_quiet)
      else $error("slot above 3 driven");
   a_slot0_upper: assert property (p_slot0_upper)
      else $error("slot 0 upper bits driven");
   a_slot0_low: assert property (p_slot0_low)
      else $error("slot 0 low bits not driven");
   a_pcm_driven: assert property (p_pcm_driven)
      else $error("pcm slot not driven");
   a_slot1_whole: assert property (p_slot1_whole)
      else $error("slot 1 drive changed within the slot");
   a_frame_spacing: assert property (p_frame_spacing)
      else $error("frame pulse not 512 falls apart");
   a_clock_half: assert property (p_clock_half)
      else $error("link clock high phase wrong length");
   c_frame_start: cover property (seen && fall && !frame_pulse_in_n);
   c_slot1_on: cover property (seen && fidx == 9'd20 && age > 8'h0A && serial_out_stream_oe);
   c_slot1_off: cover property (seen && fidx == 9'd20 && age > 8'h0A && !serial_out_stream_oe);
endmodule // tscp_link_asserts

// File: dv/testbench.sv
// self-checking bench: device end and transceiver end joined by the link
`timescale 1ns/1ps
module testbench
   import tscp_pkg::*;
   ;
   typedef struct packed {
      logic [3:0]  en;
      logic [7:0]  cc;
      logic [1:0]  hd;
      logic [7:0]  pcm;
      logic [31:0] tx;
      logic [31:0] rx;
      logic [7:0]  prx;
   } tscp_row_t;
   logic              clk_sys = 1'b0;
   logic              reset;
   logic [REG_AW-1:0] reg_addr;
   logic              reg_wr, hdlc_rx_valid, pcm_rx_valid, frame_locked;
   logic [7:0]        reg_wdata, reg_rdata, pcm_tx_byte, pcm_rx_byte, paddr, d8;
   logic [1:0]        hdlc_tx_bits, hdlc_rx_bits;
   logic              psel, penable, pwrite, pready, pslverr, err;
   logic [31:0]       pwdata, prdata, rd;
   int                fail_count = 0;
   int                compares = 0;
   // inputs, then the received slot word and pcm byte they should give
   tscp_row_t rows [2] = '{
      '{4'hF, 8'hB4, 2'h2, 8'h3C, 32'h0296_C35A, 32'hFEB4_3C00, 8'hC3},
      '{4'h8, 8'h5A, 2'h1, 8'hC3, 32'h01E1_7E99, 32'hFCFF_00C3, 8'h99}};

   tscp_link_if link_if ();
   tscp_device tscp_device_inst (
      .clk_sys, .reset, .link(link_if.device), .reg_addr, .reg_wr, .reg_wdata,
      .reg_rdata, .hdlc_tx_bits, .hdlc_rx_bits, .hdlc_rx_valid, .pcm_tx_byte,
      .pcm_rx_byte, .pcm_rx_valid, .frame_locked);
   tscp_xcvr tscp_xcvr_inst (
      .clk_sys, .reset, .link(link_if.xcvr), .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr);
   tscp_link_asserts tscp_link_asserts_inst (
      .clk_sys, .reset, .link_bit_clock(link_if.link_bit_clock),
      .frame_pulse_in_n(link_if.frame_pulse_in_n),
      .serial_out_stream(link_if.serial_out_stream),
      .serial_out_stream_oe(link_if.serial_out_stream_oe));

   // ------------------------------------------------------------
   // clock and helper tasks
   // ------------------------------------------------------------
   always #2 clk_sys = ~clk_sys;
   task automatic chk(input string name, input logic [31:0] exp, got);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic dev_wr(input logic [REG_AW-1:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wr    <= 1'b1;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask
   // registered read data: taken a cycle later, off the edge
   task automatic dev_rd(input logic [REG_AW-1:0] a, output logic [7:0] q);
      @(posedge clk_sys);
      reg_addr <= a;
      @(posedge clk_sys);
      @(negedge clk_sys);
      q = reg_rdata;
   endtask
   // apb master: holds request until pready at a rising edge; watchdog ends a hang
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // two frame-count steps give one whole frame with new settings
   task automatic wait_frames(input int n);
      logic [31:0] c0, c;
      logic        e;
      apb(1'b0, APB_STATUS, 32'h0, c0, e);
      do begin
         apb(1'b0, APB_STATUS, 32'h0, c, e);
      end while ((c[15:0] - c0[15:0]) < 16'(n));
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", compares, fail_count);
      if ((fail_count == 0) && (compares > 0)) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      reset = 1'b1;
      {reg_addr, reg_wr, reg_wdata, hdlc_tx_bits, pcm_tx_byte} = '0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (20) @(posedge clk_sys);
      reset <= 1'b0;
      foreach (rows[i]) begin
         dev_wr(REG_SLOT_TIMING, {4'h0, rows[i].en});
         dev_wr(REG_CTRL_CHAN, rows[i].cc);
         hdlc_tx_bits <= rows[i].hd;
         pcm_tx_byte  <= rows[i].pcm;
         apb(1'b1, APB_TX_SLOTS, rows[i].tx, rd, err);
         apb(1'b1, APB_CTRL, 32'h1, rd, err);
         wait_frames(2);
         apb(1'b0, APB_RX_SLOTS, 32'h0, rd, err);
         chk("rx slots", rows[i].rx, rd);
         dev_rd(REG_CTRL_CHAN, d8);
         chk("cc read", 32'(rows[i].tx[23:16]), 32'(d8));
         chk("hdlc rx", 32'(rows[i].tx[25:24]), 32'(hdlc_rx_bits));
         chk("pcm rx", 32'(rows[i].prx), 32'(pcm_rx_byte));
      end
      // reset in mid-run, then reset values and unmapped places
      chk("locked", 32'h1, 32'(frame_locked));
      @(posedge clk_sys);
      reset <= 1'b1;
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      @(negedge clk_sys);
      chk("locked after reset", 32'h0, 32'(frame_locked));
      dev_rd(REG_SLOT_TIMING, d8);
      chk("timing reset", 32'(SLOT_TIMING_RST), 32'(d8));
      dev_rd(REG_CTRL_CHAN, d8);
      chk("cc reset", 32'(CTRL_CHAN_RST), 32'(d8));
      dev_wr(6'h16, 8'hFF);
      dev_rd(6'h16, d8);
      chk("unmapped dev read", 32'h0, 32'(d8));
      apb(1'b1, 8'h10, 32'hFFFF_FFFF, rd, err);
      chk("apb unmapped err", 32'h1, 32'(err));
      apb(1'b0, 8'h10, 32'h0, rd, err);
      chk("apb unmapped data", 32'h0, rd);
      apb(1'b0, APB_CTRL, 32'h0, rd, err);
      chk("apb ctrl reset", APB_WORD_RST, rd);
      final_report();
   end
   // watchdog: about three frames of traffic plus margin
   initial begin
      #640us;
      fail_count++;
      final_report();
   end
endmodule // testbench
